// *** src/ddrmr_core.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - Mode-set with both bank selects zero loads the base mode value from address.
// - Stored mode holds until rewritten; the DLL reset bit clears itself after use.
// - Mode writes never touch the memory array contents.
// - Bits 2:0 length, bit 3 type, bits 6:4 latency, upper bits operating mode.
// - Burst lengths two, four and eight for both burst types.
// - Burst stays in an aligned block of burst length, wrapping at its edge.
// - Start within block from lowest one, two or three column bits.
// - One programmed length serves reads and writes alike.
// - Burst type bit picks sequential or interleaved order.
// - Beat k is (start+k) mod length, or start xor k when interleaved.
// - Read latency of two or two and a half cycles.
// - Read at edge n gives first data at edge n plus two plus the whole latency; the half flag marks the extra half.
// - Operating mode bits all zero select normal operation.
// - Operating mode with only the DLL bit set starts a DLL reset.
// - A separate extended mode register holds DLL enable and drive strength.
// - Mode-set with low bank select one, high zero loads the extended register.
module ddrmr_core
    import ddrmr_pkg::*;
#(
    parameter int COLS = COL_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bank_select,
    input wire logic [12:0] addr,
    output logic [12:0] mode_value,
    output logic [12:0] ext_mode_value,
    output logic dll_reset_pulse,
    output logic beat_valid,
    output logic beat_is_write,
    output logic [9:0] beat_col,
    output logic beat_first,
    output logic beat_half_cycle,
    output logic mode_reserved
);
    // Two-stage pin synchronisers; only stage two is read
    typedef struct packed {
        ddrmr_cmd_s s1;
        ddrmr_cmd_s s2;
        logic [12:0] mode_config_reg;
        logic [12:0] ext_mode_reg;
        logic dll_pulse;
        ddrmr_state_e state;
        logic [9:0] start_col;
        logic [2:0] beat_k;
        logic [2:0] last_k;
        logic bt;
        logic wr;
        logic half;
        logic [1:0] lat_cnt;
        logic lat_wait;
        ddrmr_beat_s beat;
        logic rsv;
    } ddrmr_state_s;

    ddrmr_state_s st_reg;
    ddrmr_state_s st_next;
    ddrmr_cmd_s pin_cmd;

    // Offset within block for beat k
    function automatic logic [2:0] ddrmr_offset(input logic [2:0] start, input logic [2:0] k,
                                               input logic ilv, input logic [2:0] mask);
        logic [2:0] raw;
        raw = ilv ? (start ^ k) : 3'((start + k));
        return raw & mask;
    endfunction

    // Block mask from burst length code
    function automatic logic [2:0] ddrmr_mask(input logic [2:0] code);
        logic [2:0] m;
        m = 3'h0;
        case (code)
            BL_CODE_2: m = 3'h1;
            BL_CODE_4: m = 3'h3;
            BL_CODE_8: m = 3'h7;
            default: m = 3'h1; // Reserved codes act as length two
        endcase
        return m;
    endfunction

    assign pin_cmd = '{cs_n: cs_n, ras_n: ras_n, cas_n: cas_n, we_n: we_n, bank: bank_select, addr: addr};

    // Next-state logic; command decode uses synchronised pins only
    always_comb begin
        logic [2:0] cmd;
        logic [2:0] msk;
        logic [2:0] off;
        logic [12:0] mv;
        cmd = {st_reg.s2.ras_n, st_reg.s2.cas_n, st_reg.s2.we_n};
        mv = st_reg.mode_config_reg;
        msk = ddrmr_mask(mv[BL_LSB +: 3]);
        off = 3'h0;
        st_next = st_reg;
        st_next.s1 = pin_cmd;
        st_next.s2 = st_reg.s1;
        st_next.dll_pulse = 1'b0;
        st_next.beat.valid = 1'b0;
        st_next.beat.first = 1'b0;
        // Self-clear of the DLL reset bit one cycle after it is taken
        if (st_reg.dll_pulse) begin
            st_next.mode_config_reg[DLL_POS] = 1'b0;
        end
        if (!st_reg.s2.cs_n && cmd == CMD_LOAD_MODE) begin
            if (st_reg.s2.bank == BS_MODE) begin
                st_next.mode_config_reg = st_reg.s2.addr;
                st_next.dll_pulse = (st_reg.s2.addr[OPM_LSB +: 6] == OPM_DLL_RST);
                st_next.rsv = (st_reg.s2.addr[OPM_LSB +: 6] != OPM_NORMAL) &&
                              (st_reg.s2.addr[OPM_LSB +: 6] != OPM_DLL_RST);
            end else if (st_reg.s2.bank == BS_EXT) begin
                st_next.ext_mode_reg = st_reg.s2.addr;
            end
        end
        // Burst sequencing; a new read or write restarts the sequence
        case (st_reg.state)
            DDRMR_IDLE: begin
            end
            DDRMR_BURST: begin
                if (st_reg.lat_wait && st_reg.lat_cnt != 2'h0) begin
                    st_next.lat_cnt = st_reg.lat_cnt - 2'h1;
                end else begin
                    off = ddrmr_offset(st_reg.start_col[2:0], st_reg.beat_k, st_reg.bt, st_reg.last_k);
                    st_next.lat_wait = 1'b0;
                    st_next.beat.valid = 1'b1;
                    st_next.beat.is_write = st_reg.wr;
                    st_next.beat.first = (st_reg.beat_k == 3'h0);
                    st_next.beat.half = st_reg.half;
                    st_next.beat.col = (st_reg.start_col & ~10'(st_reg.last_k)) | 10'(off);
                    st_next.beat_k = st_reg.beat_k + 3'h1;
                    if (st_reg.beat_k == st_reg.last_k) begin
                        st_next.state = DDRMR_IDLE;
                    end
                end
            end
            default: st_next.state = DDRMR_IDLE;
        endcase
        if (!st_reg.s2.cs_n && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
            st_next.state = DDRMR_BURST;
            st_next.start_col = st_reg.s2.addr[9:0];
            st_next.beat_k = 3'h0;
            st_next.last_k = msk;
            st_next.bt = mv[BT_POS];
            st_next.wr = (cmd == CMD_WRITE);
            st_next.half = (cmd == CMD_READ) && (mv[RL_LSB +: 3] == RL_CODE_25);
            st_next.lat_wait = (cmd == CMD_READ);
            st_next.lat_cnt = 2'(RL_WHOLE - 1);
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.s1.cs_n <= 1'b1;
            st_reg.s2.cs_n <= 1'b1;
            st_reg.mode_config_reg <= MODE_RESET;
            st_reg.ext_mode_reg <= EXT_RESET;
            st_reg.state <= DDRMR_IDLE;
            st_reg.last_k <= LAST_BEAT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    assign mode_value = st_reg.mode_config_reg;
    assign ext_mode_value = st_reg.ext_mode_reg;
    assign dll_reset_pulse = st_reg.dll_pulse;
    assign beat_valid = st_reg.beat.valid;
    assign beat_is_write = st_reg.beat.is_write;
    assign beat_col = st_reg.beat.col;
    assign beat_first = st_reg.beat.first;
    assign beat_half_cycle = st_reg.beat.half;
    assign mode_reserved = st_reg.rsv;
endmodule // ddrmr_core

// *** src/ddrmr_pkg.sv ***
package ddrmr_pkg;
    localparam int ADDR_W = 13;
    localparam int COL_W = 10;
    // Field positions of the mode value
    localparam int BL_LSB = 0;
    localparam int BT_POS = 3;
    localparam int RL_LSB = 4;
    localparam int OPM_LSB = 7;
    localparam int DLL_POS = 8;
    // Burst length codes
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    // Read latency codes
    localparam logic [2:0] RL_CODE_2 = 3'h2;
    localparam logic [2:0] RL_CODE_25 = 3'h6;
    // Operating mode values
    localparam logic [5:0] OPM_NORMAL = 6'h00;
    localparam logic [5:0] OPM_DLL_RST = 6'h02;
    // Values after reset
    localparam logic [12:0] MODE_RESET = 13'h0000;
    localparam logic [12:0] EXT_RESET = 13'h0000;
    // Command encoding {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    // Bank select codes {high, low}
    localparam logic [1:0] BS_MODE = 2'h0;
    localparam logic [1:0] BS_EXT = 2'h1;
    // Whole-cycle part of the read latency
    localparam int RL_WHOLE = 2;
    localparam logic [2:0] LAST_BEAT_RESET = 3'h0;

    typedef enum logic [1:0] {
        DDRMR_IDLE = 2'b01,
        DDRMR_BURST = 2'b10
    } ddrmr_state_e;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bank;
        logic [12:0] addr;
    } ddrmr_cmd_s;

    typedef struct packed {
        logic valid;
        logic is_write;
        logic [9:0] col;
        logic first;
        logic half;
    } ddrmr_beat_s;
endpackage

// *** testbench/ddrmr_core_properties.sv ***
`timescale 1ns/1ns
module ddrmr_chk
    import ddrmr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bank_select,
    input wire logic [12:0] addr,
    input wire logic [12:0] mode_value,
    input wire logic [12:0] ext_mode_value,
    input wire logic dll_reset_pulse,
    input wire logic beat_valid,
    input wire logic beat_is_write,
    input wire logic [9:0] beat_col,
    input wire logic beat_first,
    input wire logic beat_half_cycle
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Decoded load commands at the pins, before the input synchronisers
    wire ld = !cs_n && {ras_n, cas_n, we_n} == CMD_LOAD_MODE;
    wire ldm = ld && bank_select == BS_MODE;
    wire lde = ld && bank_select == BS_EXT;
    wire [2:0] msk = mode_value[2:0] == BL_CODE_8 ? 3'h7 : (mode_value[2:0] == BL_CODE_4 ? 3'h3 : 3'h1);
    property p_mode_src; $changed(mode_value) |-> $past(ldm, 3) || $past(ldm, 4) || $past(mode_value[DLL_POS]); endproperty
    a_mode_src: assert property (p_mode_src) else $error("mode value changed without a load");
    property p_ext_src; $changed(ext_mode_value) |-> $past(lde, 3) || $past(lde, 4); endproperty
    a_ext_src: assert property (p_ext_src) else $error("extended value changed without a load");
    property p_dll_bit; $rose(dll_reset_pulse) |-> mode_value[DLL_POS]; endproperty
    a_dll_bit: assert property (p_dll_bit) else $error("dll pulse without dll bit");
    property p_dll_clr; dll_reset_pulse |-> ##[1:2] !mode_value[DLL_POS]; endproperty
    a_dll_clr: assert property (p_dll_clr) else $error("dll bit did not clear");
    property p_pulse; dll_reset_pulse |=> !dll_reset_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("dll pulse too long");
    property p_block; beat_valid && !beat_first |-> $past(beat_valid) && beat_col[9:3] == $past(beat_col[9:3]); endproperty
    a_block: assert property (p_block) else $error("burst left its block");
    property p_order;
        beat_valid && !beat_first && !mode_value[BT_POS] |-> (beat_col[2:0] & msk) == (($past(beat_col[2:0]) + 3'h1) & msk);
    endproperty
    a_order: assert property (p_order) else $error("sequential order broken");
    property p_half; beat_valid && beat_first |-> beat_half_cycle == (!beat_is_write && mode_value[6:4] == RL_CODE_25); endproperty
    a_half: assert property (p_half) else $error("half cycle flag wrong");
endmodule // ddrmr_chk
bind ddrmr_core ddrmr_chk u_chk(.clk(clk), .rst(rst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select(bank_select), .addr(addr), .mode_value(mode_value), .ext_mode_value(ext_mode_value),
    .dll_reset_pulse(dll_reset_pulse), .beat_valid(beat_valid), .beat_is_write(beat_is_write),
    .beat_col(beat_col), .beat_first(beat_first), .beat_half_cycle(beat_half_cycle));

// *** testbench/ddrmr_ctrl_model.sv ***
`timescale 1ns/1ns
module ddrmr_ctrl_model
    import ddrmr_pkg::*;
(
    input wire logic clk,
    output ddrmr_cmd_s cmd
);
    initial cmd = {1'b1, 3'h7, 2'h0, 13'h0000};
    // One command per call, after an idle gap so banks are idle and bursts done
    task automatic issue(input logic [2:0] op, input logic [1:0] bs, input logic [12:0] a);
        repeat (6) @(posedge clk);
        #2;
        cmd = {1'b0, op, bs, a};
        @(posedge clk);
        #2;
        cmd = {1'b1, 3'h7, ~bs, ~a}; // Deselected: stale address must not look valid
    endtask
endmodule // ddrmr_ctrl_model

// *** testbench/ddrmr_core_tb_top.sv ***
`timescale 1ns/1ns
module ddrmr_core_tb_top
    import ddrmr_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    int num_errors = 0;
    int check_count = 0;
    int wdly = 0;
    // Mode the bench expects to stand once a load has settled
    logic [12:0] cur_mode = 13'h0000;
    ddrmr_cmd_s cmd;
    logic [12:0] mode_value, ext_mode_value;
    logic dll_reset_pulse, beat_valid, beat_is_write, beat_first, beat_half_cycle, mode_reserved;
    logic [9:0] beat_col;
    always #25 clk = ~clk;
    ddrmr_ctrl_model u_ctrl(.clk(clk), .cmd(cmd));
    ddrmr_core u_dut(.clk(clk), .rst(rst), .cs_n(cmd.cs_n), .ras_n(cmd.ras_n), .cas_n(cmd.cas_n), .we_n(cmd.we_n),
        .bank_select(cmd.bank), .addr(cmd.addr), .mode_value(mode_value), .ext_mode_value(ext_mode_value),
        .dll_reset_pulse(dll_reset_pulse), .beat_valid(beat_valid), .beat_is_write(beat_is_write),
        .beat_col(beat_col), .beat_first(beat_first), .beat_half_cycle(beat_half_cycle),
        .mode_reserved(mode_reserved));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Load the base register, then follow the DLL bit through its self-clear
    task automatic set_mode(input logic [5:0] op, input logic [2:0] rl, input logic bt, input logic [2:0] bl);
        u_ctrl.issue(CMD_LOAD_MODE, BS_MODE, {op, rl, bt, bl});
        cur_mode = {(op == OPM_DLL_RST) ? OPM_NORMAL : op, rl, bt, bl};
        repeat (2) @(posedge clk);
        #2;
        check(mode_value, {op, rl, bt, bl});
        check(dll_reset_pulse, op == OPM_DLL_RST);
        repeat (2) @(posedge clk);
        #2;
        check(mode_value, cur_mode);
        check({dll_reset_pulse, mode_reserved}, {1'b0, op != OPM_NORMAL && op != OPM_DLL_RST});
    endtask
    // One burst with every beat compared against the wrap order
    task automatic burst(input logic wr, input logic [9:0] s);
        int n;
        logic [2:0] m;
        logic [2:0] k;
        m = cur_mode[2:0] == BL_CODE_8 ? 3'h7 : (cur_mode[2:0] == BL_CODE_4 ? 3'h3 : 3'h1);
        u_ctrl.issue(wr ? CMD_WRITE : CMD_READ, 2'h0, {3'h0, s});
        n = 0;
        while (beat_valid !== 1'b1 && n < 20) begin
            @(posedge clk);
            #2;
            n++;
        end
        if (wr) wdly = n;
        else check(16'(n), 16'(wdly + RL_WHOLE - 1));
        for (int i = 0; i <= m; i++) begin
            k = i[2:0];
            check(beat_col, {s[9:3], (s[2:0] & ~m) | ((cur_mode[BT_POS] ? s[2:0] ^ k : s[2:0] + k) & m)});
            check({beat_valid, beat_first, beat_is_write}, {1'b1, i == 0, wr});
            if (i == 0) check(beat_half_cycle, !wr && cur_mode[RL_LSB +: 3] == RL_CODE_25);
            @(posedge clk);
            #2;
        end
        check(beat_valid, 1'b0);
    endtask
    initial begin
        #(5000 * 50);
        num_errors++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk);
        #2;
        rst = 1'b0;
        check(mode_value, MODE_RESET);
        check(ext_mode_value, EXT_RESET);
        u_ctrl.issue(CMD_LOAD_MODE, BS_EXT, 13'h0a5a);
        u_ctrl.issue(CMD_LOAD_MODE, 2'h2, 13'h1fff);
        repeat (4) @(posedge clk);
        #2;
        check(ext_mode_value, 13'h0a5a);
        check(mode_value, MODE_RESET);
        repeat (200) @(posedge clk);
        set_mode(OPM_DLL_RST, RL_CODE_2, 1'b0, BL_CODE_4);
        repeat (6) @(posedge clk);
        #2;
        check(mode_value, {OPM_NORMAL, RL_CODE_2, 1'b0, BL_CODE_4});
        // Reserved operating mode raises the flag; the next normal load drops it
        set_mode(6'h20, RL_CODE_2, 1'b0, BL_CODE_2);
        for (int c = 1; c <= 3; c++) begin
            for (int t = 0; t < 2; t++) begin
                set_mode(OPM_NORMAL, t ? RL_CODE_25 : RL_CODE_2, t[0], c[2:0]);
                burst(1'b1, 10'h2b5 + c[9:0]);
                burst(1'b0, 10'h2b5 + c[9:0]);
            end
        end
        close_out();
    end
endmodule // ddrmr_core_tb_top
